// [hdl/tcir_channel.sv]
// one timer channel: capture edge detect, compare match, pin level
// assumes count_next_in is the value the counter takes on step_in
`timescale 1ns/1ps
module tcir_channel
    import tcir_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // mode
    input wire logic buffered_in,
    input wire logic unbuffered_in,
    input wire logic [1:0] els_in,
    input wire logic toggle_on_wrap_in,
    input wire logic max_duty_in,
    // counter
    input wire logic [15:0] count_next_in,
    input wire logic step_in,
    input wire logic wrap_in,
    input wire logic [15:0] match_in,
    input wire logic capture_allow_in,
    input wire logic compare_allow_in,
    // pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    // event
    output logic event_out
);
    logic pin_prev;
    logic level;
    wire tcir_els_t els = tcir_els_t'(els_in);
    wire is_on = els != tcir_els_off;
    wire cap_mode = ~buffered_in & ~unbuffered_in & is_on;
    wire cmp_mode = (buffered_in | unbuffered_in) & is_on;
    wire rise = pin_in & ~pin_prev;
    wire fall = ~pin_in & pin_prev;
    wire edge_hit = (els == tcir_els_rise_toggle) ? rise :
        (els == tcir_els_fall_clear) ? fall : (rise | fall);
    wire cap_hit = cap_mode & capture_allow_in & edge_hit; // RULE4 RULE6 RULE18
    wire cmp_hit = cmp_mode & compare_allow_in & step_in & (count_next_in == match_in);
    wire wrap_act = cmp_mode & toggle_on_wrap_in & wrap_in;
    wire forced = max_duty_in & toggle_on_wrap_in;
    assign event_out = cap_hit | cmp_hit; // RULE4
    assign pin_out = level;
    assign pin_oe_out = cmp_mode; // RULE21

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            pin_prev <= 1'b0;
            level <= 1'b1;
        end
        else
        begin
            pin_prev <= pin_in;
            if (!is_on)
                level <= ~unbuffered_in;
            else if (wrap_act)
                level <= forced | ~level; // RULE24
            else if (cmp_hit && !forced)
                level <= (els == tcir_els_rise_toggle) ? ~level : (els == tcir_els_any_set);
        end
    end

    wrap_first_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE24
        wrap_act && cmp_hit && !forced |=> level != $past(level))
        else $error("compare won over wrap toggle");
endmodule // tcir_channel

// [hdl/tcir_defines.svh]
// register indices, field positions and reset values of the timer counter
// assumes word addressing: the bus address is the register index
`ifndef TCIR_DEFINES_SVH
`define TCIR_DEFINES_SVH
`define TCIR_IDX_SC 8'h40
`define TCIR_IDX_CNT_HI 8'h41
`define TCIR_IDX_CNT_LO 8'h42
`define TCIR_IDX_WRAP_HI 8'h43
`define TCIR_IDX_WRAP_LO 8'h44
`define TCIR_IDX_CH_BASE 8'h45
`define TCIR_CH_STRIDE 8'h03
`define TCIR_SC_FLAG 7
`define TCIR_SC_IE 6
`define TCIR_SC_HALT 5
`define TCIR_SC_RST 4
`define TCIR_SC_SEL 0
`define TCIR_CC_FLAG 7
`define TCIR_CC_IE 6
`define TCIR_CC_MSB 5
`define TCIR_CC_MSA 4
`define TCIR_CC_ELS 2
`define TCIR_CC_TOV 1
`define TCIR_CC_MAX 0
`define TCIR_SC_RESET 8'h20
`define TCIR_WRAP_RESET 16'hffff
`define TCIR_SEL_EXT 3'h7
`endif

// [hdl/tcir_pkg.sv]
// shared types of the timer counter
// assumes nothing of its surroundings
package tcir_pkg;
    typedef logic [7:0] tcir_byte_t;
    typedef logic [15:0] tcir_word_t;
    typedef enum logic [1:0] {tcir_els_off, tcir_els_rise_toggle, tcir_els_fall_clear,
        tcir_els_any_set} tcir_els_t;
endpackage

// [hdl/tcir_prescaler.sv]
// prescaler: divided bus clock or external pin edge as counter tick
// assumes the external pin is synchronous to clock_in
`timescale 1ns/1ps
`include "tcir_defines.svh"
module tcir_prescaler
    import tcir_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // control
    input wire logic enable_in,
    input wire logic clear_in,
    input wire logic [2:0] select_in,
    input wire logic ext_pin_in,
    // tick
    output logic tick_out
);
    logic [5:0] pre;
    logic ext_prev;
    wire [6:0] mask = (7'h01 << select_in) - 7'h01;
    wire div_hit = ({1'b0, pre} & mask) == mask;
    wire ext_rise = ext_pin_in & ~ext_prev;
    wire use_ext = select_in == `TCIR_SEL_EXT;
    assign tick_out = enable_in & ~clear_in & (use_ext ? ext_rise : div_hit); // RULE9 RULE25

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            pre <= 6'h00;
            ext_prev <= 1'b0;
        end
        else
        begin
            ext_prev <= ext_pin_in;
            if (clear_in)
                pre <= 6'h00; // RULE7
            else if (enable_in)
                pre <= pre + 6'h01;
        end
    end
endmodule // tcir_prescaler

// [hdl/tcir_top.sv]
// timer counter with wrap value, overflow flag and two channels on avalon-mm
// assumes word addressing, synchronous pins and an 8-bit register payload
// Behaviour
// RULE1: counter equal to wrap value sets overflow flag, next tick restarts at zero; code sets the flag on that restarting tick
// RULE2: overflow flag clears by read-while-set then zero write; new overflow wins
// RULE3: overflow request raised while flag set and overflow enable is one
// RULE4: each channel sets its flag on capture or compare; requests when enabled
// RULE5: halt bit holds the counter; reset sets it
// RULE6: halt bit suppresses captures on capture channels
// RULE7: counter reset bit clears counter and prescaler, reads zero, self-clears
// RULE8: halt plus counter reset in one write leaves counter stopped at zero
// RULE9: select codes 0 to 6 divide bus clock by 1 to 64; code 7 external pin
// RULE10: external pin selected forces the pin to input
// RULE11: high byte read latches low byte until low byte is read
// RULE12: counter bytes read-only, zero after reset and after counter reset
// RULE13: software reads low byte before leaving break after high byte read
// RULE14: wrap high write blocks overflow until wrap low write
// RULE15: reset sets wrap value to all ones
// RULE16: wait mode keeps counting, blocks bus, enabled request wakes processor
// RULE17: stop mode freezes block and keeps all state
// RULE18: break halts counter and suppresses captures
// RULE19: break without clear enable leaves flags untouched, pending step kept
// RULE20: break with clear enable allows clears which persist
// RULE21: channels independently capture or compare, buffered pair supported
// RULE22: software resets counter before new wrap value, keeps counter running
// RULE23: channel flag clears by read-while-set then zero write; new event wins
// RULE24: wrap toggle takes precedence over coinciding compare
// RULE25: counter advances one per selected prescaler tick or external edge
`timescale 1ns/1ps
`include "tcir_defines.svh"
module tcir_top
    import tcir_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [7:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    // system state
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic break_in,
    input wire logic break_clear_enable_in,
    input wire logic port_direction_bit_in,
    // pins
    input wire logic external_count_clock_pin_in,
    output logic external_count_clock_pin_oe_out,
    input wire logic [1:0] channel_pin_in,
    output logic [1:0] channel_pin_out,
    output logic [1:0] channel_pin_oe_out,
    // interrupt requests
    output logic overflow_irq_out,
    output logic [1:0] channel_irq_out,
    output logic wakeup_out
);
    // bus slave
    logic ack;
    wire req = (read_in | write_in) & ~wait_mode_in; // RULE16
    wire take = req & ~ack;
    wire rd = take & read_in;
    wire wr = take & write_in & byteenable_in[0];
    wire tcir_byte_t wd = writedata_in[7:0];
    assign waitrequest_out = ~(req & ack);
    wire a_sc = address_in == `TCIR_IDX_SC;
    wire a_chi = address_in == `TCIR_IDX_CNT_HI;
    wire a_clo = address_in == `TCIR_IDX_CNT_LO;
    wire a_whi = address_in == `TCIR_IDX_WRAP_HI;
    wire a_wlo = address_in == `TCIR_IDX_WRAP_LO;
    wire rd_sc = rd & a_sc;
    wire wr_sc = wr & a_sc;

    // status and control
    logic ovf_flag;
    logic ovf_armed;
    logic ovf_ie;
    logic halt;
    logic [2:0] clk_sel;
    logic wrap_inhibit;
    logic wrap_tick;
    wire clr_ok = ~break_in | break_clear_enable_in; // RULE19 RULE20
    wire cnt_reset = wr_sc & wd[`TCIR_SC_RST]; // RULE7
    wire ovf_event = wrap_tick & ~wrap_inhibit; // RULE1 RULE14
    wire ovf_clear = wr_sc & ~wd[`TCIR_SC_FLAG] & ovf_armed & clr_ok & ~ovf_event; // RULE2
    wire next_ovf_flag = ovf_event | (ovf_flag & ~ovf_clear); // RULE2
    wire next_ovf_armed = ~ovf_event & ~ovf_clear &
        (ovf_armed | (rd_sc & ovf_flag & clr_ok)); // RULE19

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            ovf_flag <= 1'b0;
            ovf_armed <= 1'b0;
            ovf_ie <= 1'(`TCIR_SC_RESET >> `TCIR_SC_IE);
            halt <= 1'b1; // RULE5
            clk_sel <= 3'h0; // RULE9
        end
        else
        begin
            ovf_flag <= next_ovf_flag;
            ovf_armed <= next_ovf_armed;
            if (wr_sc)
            begin
                ovf_ie <= wd[`TCIR_SC_IE];
                halt <= wd[`TCIR_SC_HALT]; // RULE5 RULE8
                clk_sel <= wd[`TCIR_SC_SEL+:3];
            end
        end
    end

    // counter
    tcir_word_t cnt;
    tcir_word_t wrap_value;
    tcir_byte_t wrap_pend;
    tcir_byte_t hold_lo;
    logic held;
    logic tick;
    wire running = ~halt & ~break_in & ~stop_mode_in; // RULE5 RULE17 RULE18
    wire at_wrap = cnt == wrap_value;
    assign wrap_tick = tick & at_wrap;
    wire tcir_word_t next_cnt = at_wrap ? 16'h0000 : cnt + 16'h0001; // RULE1 RULE25
    wire rd_chi = rd & a_chi;
    wire rd_clo = rd & a_clo;

    tcir_prescaler u_prescaler (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(running),
        .clear_in(cnt_reset),
        .select_in(clk_sel),
        .ext_pin_in(external_count_clock_pin_in),
        .tick_out(tick)
    );

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            cnt <= 16'h0000; // RULE12
            hold_lo <= 8'h00;
            held <= 1'b0;
        end
        else if (cnt_reset)
        begin
            cnt <= 16'h0000; // RULE7 RULE8 RULE12
            hold_lo <= 8'h00;
            held <= 1'b0;
        end
        else
        begin
            if (tick)
                cnt <= next_cnt; // RULE25
            if (rd_chi && !held)
            begin
                hold_lo <= cnt[7:0]; // RULE11
                held <= 1'b1;
            end
            else if (rd_clo)
                held <= 1'b0; // RULE11
        end
    end

    // wrap value
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            wrap_value <= `TCIR_WRAP_RESET; // RULE15
            wrap_pend <= 8'(`TCIR_WRAP_RESET >> 8);
            wrap_inhibit <= 1'b0;
        end
        else if (wr && a_whi)
        begin
            wrap_pend <= wd;
            wrap_inhibit <= 1'b1; // RULE14
        end
        else if (wr && a_wlo)
        begin
            wrap_value <= {wrap_pend, wd};
            wrap_inhibit <= 1'b0; // RULE14
        end
    end

    // channels
    logic [6:0] ch_ctl [2];
    logic ch_flag [2];
    logic ch_armed [2];
    logic cmp_inh [2];
    logic cap_inh [2];
    logic ch_event [2];
    logic wr_lo_ch [2];
    tcir_word_t ch_val [2];
    tcir_byte_t ch_pend [2];
    tcir_byte_t ch_rd [2];
    logic active_sel;
    logic last_wr;
    wire buffered = ch_ctl[0][`TCIR_CC_MSB];

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_ch
            localparam tcir_byte_t base_idx = `TCIR_IDX_CH_BASE + 8'(i) * `TCIR_CH_STRIDE;
            wire a_ctl = address_in == base_idx;
            wire a_hi = address_in == base_idx + 8'h01;
            wire a_lo = address_in == base_idx + 8'h02;
            wire [6:0] eff = (i == 1 && buffered) ? 7'h00 : ch_ctl[i]; // RULE21
            wire cap_mode = ~eff[`TCIR_CC_MSB] & ~eff[`TCIR_CC_MSA] &
                (eff[`TCIR_CC_ELS+:2] != 2'b00);
            wire tcir_word_t match = (i == 0 && buffered && active_sel) ? ch_val[1] : ch_val[i];
            wire evt = ch_event[i];
            wire clr = wr & a_ctl & ~wd[`TCIR_CC_FLAG] & ch_armed[i] & clr_ok & ~evt; // RULE23
            assign wr_lo_ch[i] = wr & a_lo;
            assign ch_rd[i] = a_ctl ? {ch_flag[i], ch_ctl[i]} : a_hi ? ch_val[i][15:8] :
                a_lo ? ch_val[i][7:0] : 8'h00;
            assign channel_irq_out[i] = ch_flag[i] & eff[`TCIR_CC_IE]; // RULE4 RULE16

            tcir_channel u_channel (
                .clock_in(clock_in),
                .rst_n_in(rst_n_in),
                .buffered_in(eff[`TCIR_CC_MSB]),
                .unbuffered_in(eff[`TCIR_CC_MSA]),
                .els_in(eff[`TCIR_CC_ELS+:2]),
                .toggle_on_wrap_in(eff[`TCIR_CC_TOV]),
                .max_duty_in(eff[`TCIR_CC_MAX]),
                .count_next_in(next_cnt),
                .step_in(tick),
                .wrap_in(wrap_tick),
                .match_in(match),
                .capture_allow_in(running & ~cap_inh[i]), // RULE6 RULE18
                .compare_allow_in(~cmp_inh[i]),
                .pin_in(channel_pin_in[i]),
                .pin_out(channel_pin_out[i]),
                .pin_oe_out(channel_pin_oe_out[i]),
                .event_out(ch_event[i])
            );

            always_ff @(posedge clock_in)
            begin
                if (!rst_n_in)
                begin
                    ch_ctl[i] <= 7'h00;
                    ch_flag[i] <= 1'b0;
                    ch_armed[i] <= 1'b0;
                    ch_val[i] <= 16'h0000;
                    ch_pend[i] <= 8'h00;
                    cmp_inh[i] <= 1'b0;
                    cap_inh[i] <= 1'b0;
                end
                else
                begin
                    ch_flag[i] <= evt | (ch_flag[i] & ~clr); // RULE4 RULE23
                    ch_armed[i] <= ~evt & ~clr &
                        (ch_armed[i] | (rd & a_ctl & ch_flag[i] & clr_ok)); // RULE23
                    if (wr && a_ctl)
                        ch_ctl[i] <= wd[6:0];
                    if (evt && cap_mode)
                        ch_val[i] <= cnt;
                    else if (wr && a_lo)
                        ch_val[i] <= {ch_pend[i], wd};
                    if (wr && a_hi)
                        ch_pend[i] <= wd;
                    if (wr && a_hi)
                        cmp_inh[i] <= 1'b1;
                    else if (wr && a_lo)
                        cmp_inh[i] <= 1'b0;
                    if (rd && a_hi && cap_mode)
                        cap_inh[i] <= 1'b1;
                    else if (rd && a_lo)
                        cap_inh[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // buffered pair: active value register becomes the last written one at wrap
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || !buffered)
        begin
            active_sel <= 1'b0;
            last_wr <= 1'b0;
        end
        else
        begin
            if (wr_lo_ch[1])
                last_wr <= 1'b1;
            else if (wr_lo_ch[0])
                last_wr <= 1'b0;
            if (wrap_tick)
                active_sel <= last_wr; // RULE21
        end
    end

    // read data and outputs
    wire tcir_byte_t sc_rd = {ovf_flag, ovf_ie, halt, 2'b00, clk_sel}; // RULE7
    wire tcir_byte_t lo_rd = held ? hold_lo : cnt[7:0]; // RULE11
    wire tcir_byte_t rd_mux = a_sc ? sc_rd : a_chi ? cnt[15:8] : a_clo ? lo_rd :
        a_whi ? wrap_pend : a_wlo ? wrap_value[7:0] : (ch_rd[0] | ch_rd[1]);

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            ack <= 1'b0;
            readdata_out <= 32'h00000000;
        end
        else
        begin
            ack <= take;
            if (rd)
                readdata_out <= {24'h000000, rd_mux};
        end
    end

    assign overflow_irq_out = ovf_flag & ovf_ie; // RULE3
    assign wakeup_out = overflow_irq_out | channel_irq_out[0] | channel_irq_out[1]; // RULE16
    assign external_count_clock_pin_oe_out = port_direction_bit_in &
        (clk_sel != `TCIR_SEL_EXT); // RULE10

    // checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_halt_reset;
        wr_sc && wd[`TCIR_SC_HALT] && wd[`TCIR_SC_RST];
    endsequence
    sequence s_zero_held;
        (cnt == 16'h0000 && !break_in) [*3];
    endsequence

    wrap_restart_a: assert property (wrap_tick && !cnt_reset |=> cnt == 16'h0000) // RULE1
        else $error("counter did not restart after wrap");
    flag_set_wins_a: assert property (ovf_event |=> ovf_flag) // RULE2
        else $error("overflow event lost");
    ovf_request_a: assert property (ovf_event && ovf_ie && !wr_sc |=> overflow_irq_out) // RULE3
        else $error("overflow request missing");
    halt_holds_a: assert property (halt && !cnt_reset |=> $stable(cnt)) // RULE5
        else $error("halted counter moved");
    cnt_clear_a: assert property (cnt_reset |=> cnt == 16'h0000 && !held) // RULE7
        else $error("counter reset did not clear");
    halt_zero_a: assert property (s_halt_reset |=> s_zero_held) // RULE8
        else $error("counter not stopped at zero");
    latch_low_a: assert property (rd_chi && !held && !cnt_reset |=> // RULE11
        held && hold_lo == $past(cnt[7:0]))
        else $error("low byte not latched");
    wrap_block_a: assert property (wrap_inhibit && wrap_tick && !ovf_flag |=> !ovf_flag) // RULE14
        else $error("overflow set during wrap update");
    break_halt_a: assert property (break_in && !cnt_reset |=> $stable(cnt)) // RULE18
        else $error("counter moved in break");
    break_keep_a: assert property (break_in && !break_clear_enable_in && ovf_flag |=> // RULE19
        ovf_flag)
        else $error("flag cleared in protected break");
    reset_state_a: assert property (!$past(rst_n_in) |-> halt && // RULE15
        wrap_value == `TCIR_WRAP_RESET)
        else $error("wrong state after reset");
endmodule // tcir_top

// [testbench/tcir_far_side.sv]
// model of the far side: external count clock source and channel input pins
// assumes clock_in is the bus clock of the timer; pins change right after its rising edge
`timescale 1ns/1ps
module tcir_far_side
(
    // clock
    input wire logic clock_in,
    // pins
    output logic ext_clk_out,
    output logic [1:0] chan_out
);
    initial
    begin
        ext_clk_out = 1'b0;
        chan_out = 2'b00;
    end
    // each pulse high one cycle, low one cycle
    task automatic pulse_ext(input int n);
        repeat (n)
        begin
            @(posedge clock_in);
            ext_clk_out <= ~ext_clk_out;
            @(posedge clock_in);
            ext_clk_out <= ~ext_clk_out;
        end
    endtask
    // one rising then falling edge on a channel pin
    task automatic pulse_chan(input int idx);
        @(posedge clock_in);
        chan_out[idx] <= ~chan_out[idx];
        repeat (2) @(posedge clock_in);
        chan_out[idx] <= ~chan_out[idx];
    endtask
endmodule // tcir_far_side

// [testbench/timer_counter_irq_regs_tb.sv]
// self-checking bench of the timer counter over avalon-mm
// assumes the far side model and the design files are compiled first
`timescale 1ns/1ps
`include "tcir_defines.svh"
module timer_counter_irq_regs_tb;
    import tcir_pkg::*;
    logic clock_in, rst_n_in, read_in, write_in, waitrequest_out;
    logic [7:0] address_in;
    logic [31:0] writedata_in, readdata_out, seed;
    logic [3:0] byteenable_in;
    logic wait_mode_in, stop_mode_in, break_in, break_clear_enable_in, port_direction_bit_in;
    logic ext_pin, ext_oe, ovf_irq, wakeup;
    logic [1:0] ch_in, ch_out, ch_oe, ch_irq, far_chan;
    int failures, n_compared, w, r;
    logic [31:0] exp_q[$];
    tcir_top i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
        .byteenable_in(byteenable_in), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .wait_mode_in(wait_mode_in),
        .stop_mode_in(stop_mode_in), .break_in(break_in),
        .break_clear_enable_in(break_clear_enable_in),
        .port_direction_bit_in(port_direction_bit_in),
        .external_count_clock_pin_in(ext_pin), .external_count_clock_pin_oe_out(ext_oe),
        .channel_pin_in(ch_in), .channel_pin_out(ch_out), .channel_pin_oe_out(ch_oe),
        .overflow_irq_out(ovf_irq), .channel_irq_out(ch_irq), .wakeup_out(wakeup));
    tcir_far_side i_far (.clock_in(clock_in), .ext_clk_out(ext_pin), .chan_out(far_chan));
    assign ch_in = (ch_oe & ch_out) | (~ch_oe & far_chan);
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check_bit(input string name, input logic e, input logic s);
        n_compared++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s expected %b seen %b", name, e, s);
        end
    endtask
    task automatic check_data(input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            failures++;
            $display("BAD readdata expected %h seen %h", e, s);
        end
    endtask
    // result watcher: a read completes where waitrequest is low
    always @(posedge clock_in)
    begin
        if (read_in === 1'b1 && waitrequest_out === 1'b0)
        begin
            if (exp_q.size() == 0)
                check_data(32'hffffffff, readdata_out);
            else
                check_data(exp_q.pop_front(), readdata_out);
        end
    end
    // one avalon transfer; for a read dat is the expected byte
    task automatic bus(input logic wr, input tcir_byte_t adr, input tcir_byte_t dat);
        int k;
        k = 0;
        @(posedge clock_in);
        address_in <= adr;
        writedata_in <= {24'h000000, dat};
        read_in <= !wr;
        write_in <= wr;
        if (!wr)
            exp_q.push_back({24'h000000, dat});
        do
        begin
            @(posedge clock_in);
            k++;
        end
        while (waitrequest_out !== 1'b0 && k < 100);
        if (waitrequest_out !== 1'b0)
        begin
            failures++;
            wrap_up();
        end
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask
    task automatic settle();
        repeat (5) @(negedge clock_in);
    endtask
    initial
    begin
        repeat (100000) @(posedge clock_in);
        failures++;
        wrap_up();
    end
    initial
    begin
        {rst_n_in, read_in, write_in, address_in, writedata_in} = '0;
        {wait_mode_in, stop_mode_in, break_in, break_clear_enable_in} = '0;
        port_direction_bit_in = 1'b1;
        failures = 0;
        n_compared = 0;
        seed = 32'h0f13;
        w = xs();
        byteenable_in = 4'(w) | 4'h1;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        bus(0, `TCIR_IDX_SC, 8'h20);
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        bus(0, `TCIR_IDX_CNT_LO, 8'h00);
        bus(0, `TCIR_IDX_WRAP_HI, 8'hff);
        bus(0, `TCIR_IDX_WRAP_LO, 8'hff);
        bus(1, 8'h10, 8'h55);
        bus(0, 8'h10, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            r = xs();
            port_direction_bit_in <= r[0];
            bus(1, `TCIR_IDX_SC, 8'h20 | c[7:0]);
            bus(0, `TCIR_IDX_SC, 8'h20 | c[7:0]);
            check_bit("ext oe", r[0] & (c != 7), ext_oe);
        end
        w = 2 + (xs() % 6);
        bus(1, `TCIR_IDX_SC, 8'h37);
        bus(1, `TCIR_IDX_WRAP_HI, 8'h00);
        bus(1, `TCIR_IDX_WRAP_LO, w[7:0]);
        bus(1, `TCIR_IDX_SC, 8'h47);
        i_far.pulse_ext(w);
        settle();
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        bus(0, `TCIR_IDX_CNT_LO, w[7:0]);
        check_bit("overflow irq", 1'b0, ovf_irq);
        i_far.pulse_ext(1);
        settle();
        check_bit("overflow irq", 1'b1, ovf_irq);
        check_bit("wakeup", 1'b1, wakeup);
        bus(1, `TCIR_IDX_SC, 8'hc7);
        check_bit("overflow irq", 1'b1, ovf_irq);
        bus(0, `TCIR_IDX_SC, 8'hc7);
        @(posedge clock_in);
        break_in <= 1'b1;
        r = xs();
        break_clear_enable_in <= r[0];
        bus(1, `TCIR_IDX_SC, 8'h47);
        settle();
        check_bit("overflow irq", !r[0], ovf_irq);
        i_far.pulse_ext(2);
        settle();
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        bus(0, `TCIR_IDX_CNT_LO, 8'h00);
        @(posedge clock_in);
        break_in <= 1'b0;
        bus(1, `TCIR_IDX_SC, 8'h47);
        settle();
        check_bit("overflow irq", 1'b0, ovf_irq);
        bus(1, `TCIR_IDX_WRAP_HI, 8'h00);
        i_far.pulse_ext(w + 1);
        settle();
        check_bit("overflow irq", 1'b0, ovf_irq);
        bus(1, `TCIR_IDX_WRAP_LO, w[7:0]);
        i_far.pulse_ext(2);
        bus(1, `TCIR_IDX_SC, 8'h27);
        i_far.pulse_ext(3);
        @(posedge clock_in);
        stop_mode_in <= 1'b1;
        bus(1, `TCIR_IDX_SC, 8'h07);
        i_far.pulse_ext(3);
        @(posedge clock_in);
        stop_mode_in <= 1'b0;
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        i_far.pulse_ext(3);
        settle();
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        bus(0, `TCIR_IDX_CNT_LO, 8'h02);
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        bus(0, `TCIR_IDX_CNT_LO, 8'h05);
        bus(1, `TCIR_IDX_SC, 8'h17);
        settle();
        bus(0, `TCIR_IDX_SC, 8'h07);
        bus(0, `TCIR_IDX_CNT_HI, 8'h00);
        bus(0, `TCIR_IDX_CNT_LO, 8'h00);
        bus(1, `TCIR_IDX_SC, 8'h27);
        bus(1, `TCIR_IDX_CH_BASE, 8'h44);
        i_far.pulse_chan(0);
        settle();
        check_bit("channel0 irq", 1'b0, ch_irq[0]);
        bus(1, `TCIR_IDX_SC, 8'h07);
        i_far.pulse_chan(0);
        settle();
        check_bit("channel0 irq", 1'b1, ch_irq[0]);
        bus(1, `TCIR_IDX_CH_BASE + `TCIR_CH_STRIDE, 8'h04);
        i_far.pulse_chan(1);
        settle();
        check_bit("channel1 irq", 1'b0, ch_irq[1]);
        bus(0, `TCIR_IDX_CH_BASE + `TCIR_CH_STRIDE, 8'h84);
        bus(1, `TCIR_IDX_CH_BASE + 8'h04, 8'h00);
        bus(1, `TCIR_IDX_CH_BASE + 8'h05, 8'h01);
        bus(1, `TCIR_IDX_CH_BASE + `TCIR_CH_STRIDE, 8'h14);
        bus(0, `TCIR_IDX_CH_BASE + `TCIR_CH_STRIDE, 8'h14);
        check_bit("channel1 oe", 1'b1, ch_oe[1]);
        check_bit("channel1 pin", 1'b1, ch_out[1]);
        i_far.pulse_ext(1);
        settle();
        check_bit("channel1 pin", 1'b0, ch_out[1]);
        bus(1, `TCIR_IDX_CH_BASE, 8'h00);
        bus(1, `TCIR_IDX_SC, 8'h47);
        i_far.pulse_ext(w + 1);
        settle();
        @(posedge clock_in);
        wait_mode_in <= 1'b1;
        fork
            bus(0, `TCIR_IDX_SC, 8'hc7);
            begin
                repeat (10) @(negedge clock_in);
                check_bit("wait hold", 1'b1, waitrequest_out);
                check_bit("wakeup", 1'b1, wakeup);
                @(posedge clock_in);
                wait_mode_in <= 1'b0;
            end
        join
        wrap_up();
    end
endmodule // timer_counter_irq_regs_tb
